// >>> common/pfc_pkg.sv
// Package with constants for the pause flow control receive buffer
package pfc_pkg;
  // ****************************************************************
  // Pause timing
  // ****************************************************************
  localparam int unsigned CYCLES_PER_UNIT = 2;
  localparam int unsigned PAUSE_UNITS_MIN = 1;
  localparam int unsigned PAUSE_UNITS_MAX = 255;
  localparam int unsigned PAUSE_UNITS_DEF = 255;
  localparam int unsigned UNIT_CNT_W = 8;
  // Renewal is sent this many units before the running pause expires
  localparam int unsigned RENEW_LEAD_UNITS = 4;
  // ****************************************************************
  // Buffer sizing
  // ****************************************************************
  localparam int unsigned BYTES_PER_LANE = 2;
  localparam int unsigned LANES = 1;
  localparam int unsigned ENTRY_W = 8 * BYTES_PER_LANE * LANES;
  localparam int unsigned DEPTH_MAX_LOG2 = 32;
  localparam int unsigned REG_DEPTH = 64;
  localparam int unsigned REG_THRESH = 40;
  localparam int unsigned REG_BACKUP_THRESH = 52;
  localparam int unsigned PRI_DEPTH = 64;
  localparam int unsigned PRI_THRESH = 40;
  localparam int unsigned PRI_BACKUP_THRESH = 52;
  localparam int unsigned PTR_W = 7;
  localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
endpackage : pfc_pkg

// >>> rtl/pfc_rx_fifo.sv
// Receive buffer with registered read data and occupancy count
`timescale 1ns/1ns
module pfc_rx_fifo #(
  parameter int unsigned DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [pfc_pkg::ENTRY_W-1:0] wr_data_i,
  output logic overflow_o,
  // Read side
  input wire logic rd_en_i,
  output logic [pfc_pkg::ENTRY_W-1:0] rd_data_o,
  output logic rd_valid_o,
  // Status
  output logic [pfc_pkg::PTR_W-1:0] count_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  // Count is sized from the depth, so deeper priority buffers still tell full from empty
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [31:0] CNT_SAT = 32'((1 << pfc_pkg::PTR_W) - 1);
  logic [pfc_pkg::ENTRY_W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [CW-1:0] count_reg;
  logic [31:0] count_wide;
  logic do_wr;
  logic do_rd;
  logic full;

  assign full = (count_reg == CW'(DEPTH));
  assign do_rd = rd_en_i && (count_reg != '0);
  assign do_wr = wr_en_i && (!full || do_rd);
  assign count_wide = 32'(count_reg);
  // Status count saturates; the thresholds sit far below the limit
  assign count_o = (count_wide > CNT_SAT) ? CNT_SAT[pfc_pkg::PTR_W-1:0] : count_wide[pfc_pkg::PTR_W-1:0];

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= CW'(pfc_pkg::PTR_RESET);
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      overflow_o <= 1'b0;
    end else begin
      // Pointers wrap at the depth, which need not be a power of two
      if (do_wr) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wptr_reg + 1'b1);
      end
      if (do_rd) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rptr_reg + 1'b1);
        rd_data_o <= mem_reg[rptr_reg];
      end
      rd_valid_o <= do_rd;
      overflow_o <= wr_en_i && full && !do_rd;
      count_reg <= CW'(count_reg + CW'(do_wr) - CW'(do_rd));
    end
  end

  a_no_overcount: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    count_reg <= CW'(DEPTH)) else $error("buffer count above depth");
endmodule : pfc_rx_fifo

// >>> rtl/pfc_pause_rx_buffer.sv
// Pause timing, pause generation and receive buffering for link flow control
`timescale 1ns/1ns
module pfc_pause_rx_buffer #(
  parameter bit FLOW_CTRL_EN = 1'b1,
  parameter bit BACKUP_EN = 1'b0,
  parameter bit TRIG_REG = 1'b1,
  parameter bit TRIG_PRI = 1'b1,
  parameter logic [7:0] PAUSE_UNITS = 8'hff,
  parameter int unsigned PRI_PACKETS = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Received link data, regular and priority
  input wire logic rx_reg_valid_i,
  input wire logic [pfc_pkg::ENTRY_W-1:0] rx_reg_data_i,
  input wire logic rx_pri_valid_i,
  input wire logic [pfc_pkg::ENTRY_W-1:0] rx_pri_data_i,
  // PAUSE instruction received from the far end
  input wire logic pause_rx_i,
  // User side streaming
  input wire logic usr_reg_ready_i,
  output logic usr_reg_valid_o,
  output logic [pfc_pkg::ENTRY_W-1:0] usr_reg_data_o,
  input wire logic usr_pri_ready_i,
  output logic usr_pri_valid_o,
  output logic [pfc_pkg::ENTRY_W-1:0] usr_pri_data_o,
  // Flow control towards the link
  output logic pause_tx_o,
  output logic tx_halt_o,
  // Errors
  output logic link_err_o,
  output logic link_restart_o
);
  // ****************************************************************
  // Buffers
  // ****************************************************************
  localparam int unsigned PRI_DEPTH_EFF = pfc_pkg::PRI_DEPTH * PRI_PACKETS;
  logic [pfc_pkg::PTR_W-1:0] reg_cnt;
  logic [pfc_pkg::PTR_W-1:0] pri_cnt;
  logic reg_ovf;
  logic pri_ovf;

  // Entries are ENTRY_W wide: two bytes for every lane
  pfc_rx_fifo #(.DEPTH(pfc_pkg::REG_DEPTH)) u_reg_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(rx_reg_valid_i),
    .wr_data_i(rx_reg_data_i),
    .overflow_o(reg_ovf),
    .rd_en_i(usr_reg_ready_i),
    .rd_data_o(usr_reg_data_o),
    .rd_valid_o(usr_reg_valid_o),
    .count_o(reg_cnt)
  );

  // Priority depth covers whole packets times the selected packet count
  pfc_rx_fifo #(.DEPTH(PRI_DEPTH_EFF)) u_pri_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(rx_pri_valid_i),
    .wr_data_i(rx_pri_data_i),
    .overflow_o(pri_ovf),
    .rd_en_i(usr_pri_ready_i),
    .rd_data_o(usr_pri_data_o),
    .rd_valid_o(usr_pri_valid_o),
    .count_o(pri_cnt)
  );

  // ****************************************************************
  // Threshold detection
  // ****************************************************************
  // Space between threshold and depth is headroom for data in flight
  logic above_main;
  logic above_backup;
  assign above_main = FLOW_CTRL_EN &&
    ((TRIG_REG && reg_cnt >= pfc_pkg::PTR_W'(pfc_pkg::REG_THRESH)) ||
     (TRIG_PRI && pri_cnt >= pfc_pkg::PTR_W'(pfc_pkg::PRI_THRESH)));
  assign above_backup = FLOW_CTRL_EN && BACKUP_EN &&
    ((TRIG_REG && reg_cnt >= pfc_pkg::PTR_W'(pfc_pkg::REG_BACKUP_THRESH)) ||
     (TRIG_PRI && pri_cnt >= pfc_pkg::PTR_W'(pfc_pkg::PRI_BACKUP_THRESH)));

  // ****************************************************************
  // Unit tick
  // ****************************************************************
  logic tick_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= !tick_reg;
    end
  end

  // ****************************************************************
  // Receiver side: PAUSE issue and renewal
  // ****************************************************************
  // Local model of how long the far transmitter stays halted
  logic [pfc_pkg::UNIT_CNT_W-1:0] far_left_reg;
  logic above_main_d_reg;
  logic backup_sent_reg;
  logic send_now;
  assign send_now = (above_main && !above_main_d_reg && far_left_reg == '0) ||
    (above_main && far_left_reg == pfc_pkg::UNIT_CNT_W'(pfc_pkg::RENEW_LEAD_UNITS) && tick_reg) ||
    (above_backup && !backup_sent_reg);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pause_tx_o <= 1'b0;
      far_left_reg <= '0;
      above_main_d_reg <= 1'b0;
      backup_sent_reg <= 1'b0;
    end else begin
      above_main_d_reg <= above_main;
      pause_tx_o <= send_now;
      if (send_now) begin
        far_left_reg <= PAUSE_UNITS;
      end else if (tick_reg && far_left_reg != '0) begin
        far_left_reg <= far_left_reg - 8'h01;
      end
      if (!above_main) begin
        backup_sent_reg <= 1'b0;
      end else if (above_backup && send_now) begin
        backup_sent_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Transmitter side: pause timer
  // ****************************************************************
  logic [pfc_pkg::UNIT_CNT_W-1:0] units_reg;
  logic tx_phase_reg;
  logic halt_on;
  assign halt_on = FLOW_CTRL_EN && pause_rx_i;
  // Own phase restarted by every PAUSE: the free tick would cut the first unit short
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_phase_reg <= 1'b0;
    end else if (halt_on) begin
      tx_phase_reg <= 1'b0;
    end else begin
      tx_phase_reg <= !tx_phase_reg;
    end
  end
  // A single halt covers both ports, whichever buffer triggered it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      units_reg <= '0;
      tx_halt_o <= 1'b0;
    end else begin
      if (halt_on) begin
        units_reg <= PAUSE_UNITS;
        tx_halt_o <= 1'b1;
      end else if (tx_phase_reg && units_reg != '0) begin
        units_reg <= units_reg - 8'h01;
        tx_halt_o <= (units_reg != 8'h01);
      end
    end
  end

  // ****************************************************************
  // Overflow handling
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      link_err_o <= 1'b0;
      link_restart_o <= 1'b0;
    end else begin
      link_err_o <= !FLOW_CTRL_EN && (reg_ovf || pri_ovf);
      link_restart_o <= link_err_o;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_param_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    PAUSE_UNITS >= 8'h01) else $error("pause length out of range");
  a_pause_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_on |=> units_reg == PAUSE_UNITS) else $error("pause not reloaded");
  a_unit_steps: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!halt_on && units_reg != '0 && tx_phase_reg) |=> units_reg == $past(units_reg) - 8'h01)
    else $error("pause unit step wrong");
  a_halt_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_on ##1 !halt_on [*2] |-> tx_halt_o) else $error("halt dropped early");
  a_halt_ends: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (units_reg == '0 && !halt_on) [*2] |-> !tx_halt_o) else $error("halt outlived pause");
  a_first_pause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (above_main && !above_main_d_reg && far_left_reg == '0) |=> pause_tx_o)
    else $error("no pause on threshold");
  a_renew_pause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (above_main && tick_reg && far_left_reg == pfc_pkg::UNIT_CNT_W'(pfc_pkg::RENEW_LEAD_UNITS))
    |=> pause_tx_o ##1 far_left_reg == PAUSE_UNITS) else $error("pause not renewed");
  a_error_report: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!FLOW_CTRL_EN && reg_ovf) |=> link_err_o ##1 link_restart_o)
    else $error("overflow not reported");
  a_backup_pause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (above_backup && !backup_sent_reg) |=> pause_tx_o) else $error("no backup pause");
endmodule : pfc_pause_rx_buffer

// >>> tb/pfc_far_end_model.sv
// Far-end transmitter model that obeys PAUSE instructions
`timescale 1ns/1ns
module pfc_far_end_model #(
  parameter int unsigned UNITS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control and link
  input wire logic send_en_i,
  input wire logic pause_i,
  output logic valid_o,
  output logic [pfc_pkg::ENTRY_W-1:0] data_o
);
  int halt_reg;
  logic [pfc_pkg::ENTRY_W-1:0] seq_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      halt_reg <= 0;
    end else if (pause_i) begin
      halt_reg <= 2 * UNITS;
    end else if (halt_reg > 0) begin
      halt_reg <= halt_reg - 1;
    end
  end
  // Idle data is inverted so a stale word never passes for fresh
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      valid_o <= 1'b0;
      seq_reg <= 16'h0000;
      data_o <= 16'hffff;
    end else if (send_en_i && halt_reg == 0 && !pause_i) begin
      valid_o <= 1'b1;
      data_o <= seq_reg;
      seq_reg <= seq_reg + 16'h0001;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule : pfc_far_end_model

// >>> tb/pfc_pause_rx_buffer_tb_top.sv
// Self-checking bench for the pause flow control receive buffer
`timescale 1ns/1ns
module pfc_pause_rx_buffer_tb_top;
  localparam int unsigned P = 8;
  logic clk_i = 1'b0, rst_b_i = 1'b0, send_en = 1'b0, pause_rx = 1'b0;
  logic rv, pv = 1'b0, rdy_r = 1'b0, rdy_p = 1'b0, ovf_wr = 1'b0;
  logic [15:0] rd, pd = 16'h0000, ur, up;
  logic uvr, uvp, ptx, halt, err, rst1, err2, rst2, ptx_bk;
  int err_count = 0, comparisons = 0, pauses = 0, writes = 0, pops = 0, errs = 0, n, t;
  logic [15:0] reg_exp = 16'h0000;
  logic [15:0] q[$];
  always #5 clk_i = ~clk_i;
  pfc_far_end_model #(.UNITS(P)) pfc_far_end_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .send_en_i(send_en), .pause_i(ptx), .valid_o(rv), .data_o(rd));
  pfc_pause_rx_buffer #(.PAUSE_UNITS(8'h08)) pfc_pause_rx_buffer_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .rx_reg_valid_i(rv), .rx_reg_data_i(rd), .rx_pri_valid_i(pv), .rx_pri_data_i(pd),
    .pause_rx_i(pause_rx), .usr_reg_ready_i(rdy_r), .usr_reg_valid_o(uvr), .usr_reg_data_o(ur),
    .usr_pri_ready_i(rdy_p), .usr_pri_valid_o(uvp), .usr_pri_data_o(up), .pause_tx_o(ptx),
    .tx_halt_o(halt), .link_err_o(err), .link_restart_o(rst1));
  // Second copy without flow control, fed on its own write strobe
  pfc_pause_rx_buffer #(.FLOW_CTRL_EN(1'b0), .PAUSE_UNITS(8'h08)) pfc_pause_rx_buffer_nofc_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .rx_reg_valid_i(ovf_wr), .rx_reg_data_i(pd),
    .rx_pri_valid_i(pv), .rx_pri_data_i(pd), .pause_rx_i(pause_rx), .usr_reg_ready_i(rdy_r),
    .usr_reg_valid_o(), .usr_reg_data_o(), .usr_pri_ready_i(rdy_p), .usr_pri_valid_o(),
    .usr_pri_data_o(), .pause_tx_o(), .tx_halt_o(), .link_err_o(err2), .link_restart_o(rst2));
  // Third copy with the backup pause, filled by the same strobe as the second
  pfc_pause_rx_buffer #(.BACKUP_EN(1'b1), .PAUSE_UNITS(8'h08)) pfc_pause_rx_buffer_bk_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .rx_reg_valid_i(ovf_wr), .rx_reg_data_i(pd),
    .rx_pri_valid_i(pv), .rx_pri_data_i(pd), .pause_rx_i(pause_rx), .usr_reg_ready_i(rdy_r),
    .usr_reg_valid_o(), .usr_reg_data_o(), .usr_pri_ready_i(rdy_p), .usr_pri_valid_o(),
    .usr_pri_data_o(), .pause_tx_o(ptx_bk), .tx_halt_o(), .link_err_o(), .link_restart_o());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  // Waits for a level on a signal and returns the cycles spent
  task automatic wait_for(ref logic s, input logic lvl, output int c);
    c = 0;
    while (s !== lvl) begin
      cyc(1);
      c++;
      if (c > 600) begin
        check(0, 1);
        results();
      end
    end
  endtask : wait_for
  task automatic pulse_pause;
    pause_rx = 1'b1;
    cyc(1);
    pause_rx = 1'b0;
  endtask : pulse_pause
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction : in_rng
  always @(negedge clk_i) begin
    pauses += ptx;
    writes += rv;
    errs += err;
    errs += rst1;
    if (uvr === 1'b1) begin
      pops++;
      check(ur, reg_exp);
      reg_exp++;
    end
    if (uvp === 1'b1) check(up, q.pop_front());
  end
  initial begin
    void'($urandom(32'h8b6762a8));
    cyc(16);
    rst_b_i = 1'b1;
    cyc(2);
    pulse_pause();
    check(halt, 1);
    wait_for(halt, 1'b0, n);
    check(n, 2 * P);
    pulse_pause();
    t = 3 + $urandom % 8;
    cyc(t);
    pulse_pause();
    wait_for(halt, 1'b0, n);
    check(n, 2 * P);
    send_en = 1'b1;
    wait_for(ptx, 1'b1, n);
    check(in_rng(writes, 40, 42), 1);
    cyc(1);
    wait_for(ptx, 1'b1, n);
    check(in_rng(n, 2 * (P - 4), 2 * (P - 4) + 1), 1);
    t = pauses;
    cyc(40);
    check(pauses - t, 4);
    send_en = 1'b0;
    rdy_r = 1'b1;
    cyc(100);
    check(pops, writes);
    check(errs, 0);
    t = pauses;
    for (int i = 0; i < 40; i++) begin
      pd = 16'($urandom);
      q.push_back(pd);
      pv = 1'b1;
      cyc(1);
    end
    pv = 1'b0;
    cyc(3);
    check(pauses - t, 1);
    rdy_p = 1'b1;
    cyc(60);
    check(q.size(), 0);
    rdy_r = 1'b0;
    ovf_wr = 1'b1;
    cyc(53);
    check(ptx_bk, 1);
    cyc(12);
    ovf_wr = 1'b0;
    wait_for(err2, 1'b1, n);
    check(n, 1);
    cyc(1);
    check(rst2, 1);
    results();
  end
endmodule : pfc_pause_rx_buffer_tb_top
